// ### verilog/issc_top.sv
// What this block does
// [R01] Clamp polarity used only with external clamp
// [R02] External clock select bypasses internal PLL
// [R03] Per-channel clamp to ground or midscale
// [R04] Output clock invert, digital interface only
// [R05] One or two pixels per clock, digital
// [R06] Drive field: 1x high, 01 medium, 00 low
// [R07] Output disable puts data outputs high-Z
// [R08] Polarity bit sets sync-detect pin level
// [R09] Status bit 7 shows analog hsync present
// [R10] Status bit 6 shows green sync present
// [R11] Status bit 5 shows analog vsync present
// [R12] Status bit 4 shows digital clock present
// [R13] Status bit 3 shows active interface
// [R14] Status bit 2 shows hsync source used
// [R15] Status bit 1 shows vsync source used
// [R16] Interface override uses software select bit
// [R17] Interface select honoured on override or tie
// [R18] Hsync override uses software select bit
// [R19] Hsync select honoured on override or tie
// [R20] Vsync override uses software select
// [R21] Presence bits clear after idle timeout
//
// Implementation choice: the APB slave port.
module issc_top #(
  parameter int unsigned PRES_TIMEOUT = issc_pkg::PRES_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Activity from the receive paths
  input  wire logic        hsync_in,
  input  wire logic        sog_in,
  input  wire logic        vsync_in,
  input  wire logic        dig_clk_in,
  input  wire logic        ext_clamp_in,
  // Clamp and clock source
  output logic             clamp_pulse_q,
  output logic             ext_clamp_used_q,
  output logic             pll_enable_q,
  output logic             ext_clock_used_q,
  output logic      [2:0]  clamp_midscale_q,
  // Output format and drive
  output logic             output_clock_invert_q,
  output logic             two_pixels_per_clock_q,
  output logic      [1:0]  drive_strength_q,
  output logic             data_out_enable_q,
  output logic             output_high_impedance_q,
  output logic             sync_detect_output_pin_q,
  // Chosen sources
  output logic             digital_active_q,
  output logic             hsync_from_green_q,
  output logic             vsync_from_green_q
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic [7:0]             cc_q;
  logic [7:0]             of_q;
  logic [7:0]             os_q;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic                   hit;
  logic                   setup_ph;
  logic                   wr_en;
  logic [5:0]             idx;
  logic                   hs_pres;
  logic                   sog_pres;
  logic                   vs_pres;
  logic                   dclk_pres;
  logic                   if_choice;
  logic                   hs_choice;
  logic                   vs_choice;
  logic                   analog_pres;
  logic                   active_pres;
  logic [issc_pkg::TMR_W-1:0] timeout;
  issc_pkg::issc_status_t status;

  // ------------------------------------------------------------------
  // Function: register index from a byte address
  // ------------------------------------------------------------------
  function automatic logic [5:0] addr_idx(input logic [7:0] a);
    addr_idx = a[7:2];
  endfunction

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  assign idx      = addr_idx(paddr);
  assign hit      = (paddr[1:0] == 2'h0) &&
                    ((idx == issc_pkg::IDX_CLAMP_CLK) ||
                     (idx == issc_pkg::IDX_OUT_FMT)   ||
                     (idx == issc_pkg::IDX_STATUS)    ||
                     (idx == issc_pkg::IDX_OVR_SEL));
  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite & hit & pstrb[0];

  // Zero-wait answer; unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = rdata_q;

  // ------------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------------

  // Clamp and clock source control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cc_q <= issc_pkg::CC_RESET;
    else if (wr_en && idx == issc_pkg::IDX_CLAMP_CLK)
      cc_q <= pwdata[7:0];
  end

  // Output format and drive control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      of_q <= issc_pkg::OF_RESET;
    else if (wr_en && idx == issc_pkg::IDX_OUT_FMT)
      of_q <= pwdata[7:0] & issc_pkg::OF_MASK;
  end

  // Interface and sync override / select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      os_q <= issc_pkg::OS_RESET;
    else if (wr_en && idx == issc_pkg::IDX_OVR_SEL)
      os_q <= pwdata[7:0] & issc_pkg::OS_MASK;
  end

  // ------------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ------------------------------------------------------------------

  // Read mux; status is a live view of the monitors
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      issc_pkg::IDX_CLAMP_CLK: rdata_d[7:0] = cc_q;
      issc_pkg::IDX_OUT_FMT:   rdata_d[7:0] = of_q;
      issc_pkg::IDX_STATUS:    rdata_d[7:0] = {status, 1'b0};
      issc_pkg::IDX_OVR_SEL:   rdata_d[7:0] = os_q;
      default:                 rdata_d      = 32'h0000_0000;
    endcase
    if (paddr[1:0] != 2'h0)
      rdata_d = 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rdata_q <= 32'h0000_0000;
    else if (setup_ph && !pwrite)
      rdata_q <= rdata_d;
  end

  // ------------------------------------------------------------------
  // Activity monitors
  // ------------------------------------------------------------------
  assign timeout = PRES_TIMEOUT[issc_pkg::TMR_W-1:0];

  // Analog hsync pin
  issc_act_mon u_mon_hs (
    .pclk      (pclk),
    .presetn   (presetn),
    .sig_in    (hsync_in),
    .timeout   (timeout),
    .present_q (hs_pres)
  );

  // Sync extracted from green
  issc_act_mon u_mon_sog (
    .pclk      (pclk),
    .presetn   (presetn),
    .sig_in    (sog_in),
    .timeout   (timeout),
    .present_q (sog_pres)
  );

  // Analog vsync pin
  issc_act_mon u_mon_vs (
    .pclk      (pclk),
    .presetn   (presetn),
    .sig_in    (vsync_in),
    .timeout   (timeout),
    .present_q (vs_pres)
  );

  // Digital interface clock
  issc_act_mon u_mon_dclk (
    .pclk      (pclk),
    .presetn   (presetn),
    .sig_in    (dig_clk_in),
    .timeout   (timeout),
    .present_q (dclk_pres)
  );

  // Analog side counts as active with either hsync source
  assign analog_pres = hs_pres | sog_pres;

  // ------------------------------------------------------------------
  // Source choices
  // ------------------------------------------------------------------

  // Active interface: analog (0) or digital (1)
  issc_src_sel u_sel_if (
    .pclk         (pclk),
    .presetn      (presetn),
    .override     (os_q[issc_pkg::OS_IF_OVR]),   // [R16]
    .select       (os_q[issc_pkg::OS_IF_SEL]),   // [R17]
    .src0_present (analog_pres),
    .src1_present (dclk_pres),
    .choice_q     (if_choice)
  );

  // Hsync source: pin (0) or green (1)
  issc_src_sel u_sel_hs (
    .pclk         (pclk),
    .presetn      (presetn),
    .override     (os_q[issc_pkg::OS_HS_OVR]),   // [R18]
    .select       (os_q[issc_pkg::OS_HS_SEL]),   // [R19]
    .src0_present (hs_pres),
    .src1_present (sog_pres),
    .choice_q     (hs_choice)
  );

  // Vsync source: pin (0) or green (1)
  issc_src_sel u_sel_vs (
    .pclk         (pclk),
    .presetn      (presetn),
    .override     (os_q[issc_pkg::OS_VS_OVR]),   // [R20]
    .select       (os_q[issc_pkg::OS_VS_SEL]),
    .src0_present (vs_pres),
    .src1_present (sog_pres),
    .choice_q     (vs_choice)
  );

  assign digital_active_q   = if_choice;
  assign hsync_from_green_q = hs_choice;
  assign vsync_from_green_q = vs_choice;

  // ------------------------------------------------------------------
  // Status view
  // ------------------------------------------------------------------
  always_comb begin
    status.hsync_present                 = hs_pres;      // [R09]
    status.sog_present                   = sog_pres;     // [R10]
    status.vsync_present                 = vs_pres;      // [R11]
    status.dig_clk_present               = dclk_pres;    // [R12]
    status.active_interface_status       = if_choice;    // [R13]
    status.active_horizontal_sync_status = hs_choice;    // [R14]
    status.active_vertical_sync_status   = vs_choice;    // [R15]
  end

  // ------------------------------------------------------------------
  // Clamp and clock source outputs
  // ------------------------------------------------------------------

  // Clamp trigger: hsync, or external clamp at its set polarity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clamp_pulse_q    <= 1'b0;
      ext_clamp_used_q <= 1'b0;
    end else begin
      ext_clamp_used_q <= cc_q[issc_pkg::CC_EXT_CLAMP];
      if (cc_q[issc_pkg::CC_EXT_CLAMP])
        clamp_pulse_q <= ~(ext_clamp_in ^
                           cc_q[issc_pkg::CC_CLAMP_POL]);   // [R01]
      else
        clamp_pulse_q <= hsync_in;
    end
  end

  // PLL bypass and per-channel clamp targets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_enable_q     <= 1'b1;
      ext_clock_used_q <= 1'b0;
      clamp_midscale_q <= 3'h0;
    end else begin
      pll_enable_q     <= ~cc_q[issc_pkg::CC_EXT_CLK];     // [R02]
      ext_clock_used_q <= cc_q[issc_pkg::CC_EXT_CLK];      // [R02]
      clamp_midscale_q <= {cc_q[issc_pkg::CC_MID_RED],
                           cc_q[issc_pkg::CC_MID_GRN],
                           cc_q[issc_pkg::CC_MID_BLU]};     // [R03]
    end
  end

  // ------------------------------------------------------------------
  // Output format, drive and sync-detect pin
  // ------------------------------------------------------------------

  // Clock invert and pixel mode only on the digital interface
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_clock_invert_q  <= 1'b0;
      two_pixels_per_clock_q <= 1'b0;
    end else begin
      output_clock_invert_q  <= of_q[issc_pkg::OF_CLK_INV] &
                                if_choice;                 // [R04]
      two_pixels_per_clock_q <= of_q[issc_pkg::OF_TWO_PIX] &
                                if_choice;                 // [R05]
    end
  end

  // Drive strength decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      drive_strength_q <= issc_pkg::DRV_HIGH;
    else if (of_q[issc_pkg::OF_DRIVE_LO+1])
      drive_strength_q <= issc_pkg::DRV_HIGH;              // [R06]
    else if (of_q[issc_pkg::OF_DRIVE_LO])
      drive_strength_q <= issc_pkg::DRV_MEDIUM;            // [R06]
    else
      drive_strength_q <= issc_pkg::DRV_LOW;               // [R06]
  end

  // Data output enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out_enable_q       <= 1'b1;
      output_high_impedance_q <= 1'b0;
    end else begin
      data_out_enable_q       <= ~of_q[issc_pkg::OF_HIZ];  // [R07]
      output_high_impedance_q <= of_q[issc_pkg::OF_HIZ];   // [R07]
    end
  end

  // Sync detect: activity on the chosen interface
  assign active_pres = if_choice ? dclk_pres : analog_pres;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      sync_detect_output_pin_q <= 1'b0;
    else
      sync_detect_output_pin_q <= ~(active_pres ^
                                    of_q[issc_pkg::OF_SDT_POL]); // [R08]
  end

endmodule

// ### verilog/issc_pkg.sv
package issc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CLAMP_CLK = 6'h0F;
  localparam logic [5:0] IDX_OUT_FMT   = 6'h10;
  localparam logic [5:0] IDX_STATUS    = 6'h11;
  localparam logic [5:0] IDX_OVR_SEL   = 6'h12;

  // ----------------------------------------------------------------
  // Clamp and clock source control fields
  // ----------------------------------------------------------------
  localparam int unsigned CC_HS_POL    = 7;
  localparam int unsigned CC_COAST_POL = 6;
  localparam int unsigned CC_EXT_CLAMP = 5;
  localparam int unsigned CC_CLAMP_POL = 4;
  localparam int unsigned CC_EXT_CLK   = 3;
  localparam int unsigned CC_MID_RED   = 2;
  localparam int unsigned CC_MID_GRN   = 1;
  localparam int unsigned CC_MID_BLU   = 0;
  localparam logic [7:0]  CC_RESET     = 8'hD0;

  // ----------------------------------------------------------------
  // Output format and drive control fields
  // ----------------------------------------------------------------
  localparam int unsigned OF_CLK_INV   = 7;
  localparam int unsigned OF_TWO_PIX   = 6;
  localparam int unsigned OF_DRIVE_LO  = 4;
  localparam int unsigned OF_HIZ       = 3;
  localparam int unsigned OF_SDT_POL   = 2;
  localparam logic [7:0]  OF_MASK      = 8'hFC;
  localparam logic [7:0]  OF_RESET     = 8'h34;

  // ----------------------------------------------------------------
  // Interface and sync override / select fields
  // ----------------------------------------------------------------
  localparam int unsigned OS_IF_OVR    = 7;
  localparam int unsigned OS_IF_SEL    = 6;
  localparam int unsigned OS_HS_OVR    = 5;
  localparam int unsigned OS_HS_SEL    = 4;
  localparam int unsigned OS_VS_OVR    = 3;
  localparam int unsigned OS_VS_SEL    = 2;
  localparam logic [7:0]  OS_MASK      = 8'hFC;
  localparam logic [7:0]  OS_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Presence timeout
  // ----------------------------------------------------------------
  localparam int unsigned PCLK_KHZ          = 50000;
  localparam int unsigned PRES_TIMEOUT_MS   = 25;
  localparam int unsigned PRES_TIMEOUT_CYC  = PRES_TIMEOUT_MS * PCLK_KHZ;
  localparam int unsigned TMR_W             = 21;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    DRV_LOW,
    DRV_MEDIUM,
    DRV_HIGH
  } issc_drive_t;

  // Detection status, laid out as bits 7..1 of the status register
  typedef struct packed {
    logic hsync_present;
    logic sog_present;
    logic vsync_present;
    logic dig_clk_present;
    logic active_interface_status;
    logic active_horizontal_sync_status;
    logic active_vertical_sync_status;
  } issc_status_t;

endpackage

// ### verilog/issc_act_mon.sv
// --------------------------------------------------------------------
// Activity monitor: presence held while edges keep arriving
// --------------------------------------------------------------------
module issc_act_mon (
  // Clock and reset
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  // Monitored signal and timeout
  input  wire logic                      sig_in,
  input  wire logic [issc_pkg::TMR_W-1:0] timeout,
  // Presence
  output logic                           present_q
);

  logic                      sig_q;
  logic [issc_pkg::TMR_W-1:0] cnt_q;
  logic                      edge_seen;

  assign edge_seen = sig_in ^ sig_q;

  // Previous level for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sig_q <= 1'b0;
    else          sig_q <= sig_in;
  end

  // Idle counter, restarted by every edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= '0;
      present_q <= 1'b0;
    end else if (edge_seen) begin
      cnt_q     <= '0;
      present_q <= 1'b1;                     // [R21]
    end else if (cnt_q >= timeout) begin
      present_q <= 1'b0;                     // [R21]
    end else begin
      cnt_q     <= cnt_q + 1'b1;
    end
  end

endmodule

// ### verilog/issc_src_sel.sv
// --------------------------------------------------------------------
// Source choice: override, or automatic with select on a tie
// --------------------------------------------------------------------
module issc_src_sel (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Software control
  input  wire logic override,
  input  wire logic select,
  // Detected sources (0 side, 1 side)
  input  wire logic src0_present,
  input  wire logic src1_present,
  // Chosen source
  output logic      choice_q
);

  logic choice_d;

  // Override wins; both present follows select; else the live one
  always_comb begin
    if (override)
      choice_d = select;
    else if (src0_present && src1_present)
      choice_d = select;
    else
      choice_d = src1_present;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) choice_q <= 1'b0;
    else          choice_q <= choice_d;
  end

endmodule

// ### tb/issc_top_monitor.sv
module issc_top_monitor (
  // Clock and reset
  input logic        pclk,
  input logic        presetn,
  // APB
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic        pslverr,
  // Activity and outputs
  input logic        hsync_in,
  input logic        clamp_pulse_q,
  input logic        ext_clamp_used_q,
  input logic        pll_enable_q,
  input logic        ext_clock_used_q,
  input logic [2:0]  clamp_midscale_q,
  input logic        output_clock_invert_q,
  input logic        two_pixels_per_clock_q,
  input logic [1:0]  drive_strength_q,
  input logic        data_out_enable_q,
  input logic        output_high_impedance_q,
  input logic        digital_active_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Write steps
  // ----------------------------------------------------------------
  function automatic logic [1:0] drv_of(input logic [1:0] f);
    return f[1] ? 2'h2 : {1'b0, f[0]};
  endfunction
  sequence s_take;
    psel && penable && pwrite && pstrb[0];
  endsequence
  sequence s_wr_fmt;
    s_take ##0 paddr == {issc_pkg::IDX_OUT_FMT, 2'b00};
  endsequence
  sequence s_wr_cc;
    s_take ##0 paddr == {issc_pkg::IDX_CLAMP_CLK, 2'b00};
  endsequence

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_pll_vs_ext: assert property (pll_enable_q == !ext_clock_used_q)
    else $error("pll enable wrong");
  a_hiz_vs_enable: assert property (
    data_out_enable_q == !output_high_impedance_q)
    else $error("enable vs high-Z");
  a_drive_legal: assert property (drive_strength_q != 2'h3)
    else $error("illegal drive code");
  a_fmt_hiz_write: assert property (s_wr_fmt |-> ##2
    output_high_impedance_q == $past(pwdata[3], 2))
    else $error("high-Z missed write");
  a_fmt_drive_write: assert property (s_wr_fmt |-> ##2
    drive_strength_q == drv_of($past(pwdata[5:4], 2)))
    else $error("drive missed write");
  a_cc_src_write: assert property (s_wr_cc |-> ##2
    {ext_clock_used_q, clamp_midscale_q} == $past(pwdata[3:0], 2))
    else $error("clamp ctrl missed write");
  a_clkinv_digital: assert property (output_clock_invert_q |->
    digital_active_q || $past(digital_active_q))
    else $error("invert on analog");
  a_twopix_digital: assert property (two_pixels_per_clock_q |->
    digital_active_q || $past(digital_active_q))
    else $error("two pixels on analog");
  a_clamp_hsync: assert property (!ext_clamp_used_q &&
    $past(!ext_clamp_used_q) && $past(!ext_clamp_used_q, 2)
    |-> clamp_pulse_q == $past(hsync_in))
    else $error("clamp not hsync");
  a_err_misalign: assert property (
    psel && penable && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("no misalign error");
endmodule

bind issc_top issc_top_monitor u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
  .pslverr, .hsync_in, .clamp_pulse_q, .ext_clamp_used_q, .pll_enable_q,
  .ext_clock_used_q, .clamp_midscale_q, .output_clock_invert_q,
  .two_pixels_per_clock_q, .drive_strength_q, .data_out_enable_q,
  .output_high_impedance_q, .digital_active_q);

// ### tb/issc_video_src.sv
module issc_video_src (
  // Clock and reset
  input  logic       pclk,
  input  logic       presetn,
  // Which sources run: hsync, green sync, vsync, digital clock
  input  logic [3:0] act_en,
  // Activity toward the block
  output logic       hsync_q,
  output logic       sog_q,
  output logic       vsync_q,
  output logic       dig_clk_q,
  output logic       ext_clamp_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [7:0] lfsr_q;

  // Enabled sources toggle every 4 cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      {hsync_q, sog_q, vsync_q, dig_clk_q} <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      if (cnt_q == 2'h3) begin
        {hsync_q, sog_q, vsync_q, dig_clk_q} <=
          {hsync_q, sog_q, vsync_q, dig_clk_q} ^ act_en;
      end
    end
  end

  // Pseudo-random external clamp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q      <= 8'hA5;
      ext_clamp_q <= 1'b0;
    end else begin
      lfsr_q      <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4]};
      ext_clamp_q <= lfsr_q[0];
    end
  end
endmodule

// ### tb/tb_issc_top.sv
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
  fail_count++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
  end end

module tb_issc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         PT     = 20;
  localparam logic [7:0] A_CC   = {issc_pkg::IDX_CLAMP_CLK, 2'b00};
  localparam logic [7:0] A_FMT  = {issc_pkg::IDX_OUT_FMT, 2'b00};
  localparam logic [7:0] A_STAT = {issc_pkg::IDX_STATUS, 2'b00};
  localparam logic [7:0] A_OVR  = {issc_pkg::IDX_OVR_SEL, 2'b00};
  logic        pclk = 1'b0, presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, d, o, f;
  logic [3:0]  pstrb = 4'hF, act_en = 4'h8;
  logic [7:0]  st;
  logic [2:0]  midscale;
  logic [1:0]  drv;
  logic        pready, pslverr, err, e, pres;
  logic        hs_in, sog_in, vs_in, dclk_in, xclamp_in, clamp_q;
  logic        xclamp_used, pll_en, xclk_used, output_clock_invert, two_pix, out_en;
  logic        hiz, sdt_pin, dig_act, hs_green, vs_green;
  integer      seed = 22568;
  int          fail_count = 0, comparisons = 0;

  issc_top #(.PRES_TIMEOUT(PT)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hsync_in(hs_in), .sog_in(sog_in), .vsync_in(vs_in),
    .dig_clk_in(dclk_in), .ext_clamp_in(xclamp_in),
    .clamp_pulse_q(clamp_q), .ext_clamp_used_q(xclamp_used),
    .pll_enable_q(pll_en), .ext_clock_used_q(xclk_used),
    .clamp_midscale_q(midscale), .output_clock_invert_q(output_clock_invert),
    .two_pixels_per_clock_q(two_pix), .drive_strength_q(drv),
    .data_out_enable_q(out_en), .output_high_impedance_q(hiz),
    .sync_detect_output_pin_q(sdt_pin), .digital_active_q(dig_act),
    .hsync_from_green_q(hs_green), .vsync_from_green_q(vs_green));
  issc_video_src u_src (
    .pclk(pclk), .presetn(presetn), .act_en(act_en), .hsync_q(hs_in),
    .sog_q(sog_in), .vsync_q(vs_in), .dig_clk_q(dclk_in),
    .ext_clamp_q(xclamp_in));

  // Clock and watchdog
  initial forever #10 pclk = ~pclk;
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    tally_and_finish;
  end

  // ----------------------------------------------------------------
  // Bus tasks and expectations
  // ----------------------------------------------------------------
  task automatic apb_xfer(input logic w, input logic [7:0] a,
                          input logic [31:0] wd, input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w;
    paddr <= a; pwdata <= wd; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    apb_xfer(1'b1, a, wd, 4'hF);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    apb_xfer(1'b0, a, 32'h0, 4'hF);
    `CHK(rd, {24'h0, x})
    `CHK(err, 1'b0)
  endtask
  function automatic logic pick(logic ov, logic sel, logic p0, logic p1);
    return ov ? sel : ((p0 && p1) ? sel : p1);
  endfunction
  function automatic logic [7:0] exp_st(logic [3:0] a, logic [7:0] v);
    return {a, pick(v[7], v[6], a[3] | a[2], a[0]),
            pick(v[5], v[4], a[3], a[2]), pick(v[3], v[2], a[1], a[2]),
            1'b0};
  endfunction
  task automatic check_defaults;
    rd_chk(A_CC, issc_pkg::CC_RESET);
    rd_chk(A_FMT, issc_pkg::OF_RESET);
    rd_chk(A_OVR, issc_pkg::OS_RESET);
    `CHK({pll_en, out_en, drv}, 4'hE)
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check_defaults;
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      d = $random(seed);
      wr(A_CC, d);
      repeat (2) @(posedge pclk);
      `CHK({xclk_used, pll_en}, {d[3], !d[3]})
      `CHK({xclamp_used, midscale}, {d[5], d[2:0]})
      rd_chk(A_CC, d[7:0]);
    end
    for (int p = 0; p < 2; p++) begin
      wr(A_CC, p ? 32'h30 : 32'h20);
      repeat (2) @(posedge pclk);
      repeat (8) begin
        @(negedge pclk) e = xclamp_in;
        @(negedge pclk) `CHK(clamp_q, p ? e : !e)
      end
    end
    $display("clamp test done");
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      d[5:4] = i[1:0];
      wr(A_FMT, d);
      repeat (2) @(posedge pclk);
      `CHK(drv, (i > 1) ? 2'h2 : i[1:0])
      `CHK({hiz, out_en}, {d[3], !d[3]})
      rd_chk(A_FMT, d[7:0] & issc_pkg::OF_MASK);
    end
    $display("format test done");
    for (int i = 0; i < 10; i++) begin
      act_en <= (i == 0) ? 4'hF : 4'($random(seed));
      o = (i < 2) ? 32'h0 : $random(seed);
      f = $random(seed);
      wr(A_OVR, o);
      wr(A_FMT, f);
      repeat (3 * PT) @(posedge pclk);
      st = exp_st(act_en, o[7:0]);
      rd_chk(A_STAT, st);
      rd_chk(A_OVR, o[7:0] & issc_pkg::OS_MASK);
      `CHK({dig_act, hs_green, vs_green}, st[3:1])
      pres = st[3] ? act_en[0] : (act_en[3] | act_en[2]);
      `CHK(sdt_pin, f[2] ? pres : !pres)
      `CHK({output_clock_invert, two_pix}, {f[7] & st[3], f[6] & st[3]})
    end
    wr(A_OVR, 32'h0);
    act_en <= 4'h0;
    repeat (3 * PT) @(posedge pclk);
    rd_chk(A_STAT, 8'h00);
    $display("detect test done");
    apb_xfer(1'b0, 8'h80, 32'h0, 4'hF);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb_xfer(1'b1, A_FMT | 8'h01, 32'hFF, 4'hF);
    `CHK(err, 1'b1)
    apb_xfer(1'b1, A_FMT, 32'hFF, 4'hE);
    wr(A_STAT, 32'hFF);
    rd_chk(A_STAT, 8'h00);
    rd_chk(A_FMT, f[7:0] & issc_pkg::OF_MASK);
    $display("refusal test done");
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check_defaults;
    $display("reset 2 test done");
    tally_and_finish;
  end
endmodule
